// [src/cpu_control_and_block_compare.sv]
`default_nettype none
module cpu_control_and_block_compare
	import cpu_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Instruction issue
	input wire logic issue_valid_in,
	input wire instr_t issue_instr_in,
	output logic issue_ready_out,
	output logic done_out,
	// Operand load for the compare
	input wire logic [15:0] source_pointer_pair_in,
	input wire logic [15:0] target_pointer_pair_in,
	input wire logic [7:0] count_in,
	// Data memory read port and unused write strobe
	output logic mem_rd_out,
	output logic [15:0] mem_addr_out,
	input wire logic [7:0] mem_data_in,
	output logic mem_wr_out,
	// Interrupt and macro service
	input wire logic irq_req_in,
	input wire logic irq_maskable_in,
	input wire logic macro_req_in,
	input wire logic resume_in,
	output logic irq_ack_out,
	output logic macro_ack_out,
	output logic trap_out,
	// Architectural state
	output flags_t flags_out,
	output logic [15:0] source_pointer_pair_out,
	output logic [15:0] target_pointer_pair_out,
	output logic [7:0] count_out,
	output logic [7:0] standby_control_reg,
	output logic [7:0] watchdog_mode_reg,
	output logic [2:0] bank_select_field,
	output logic register_set_select_flag,
	output logic irq_accept_enable_flag,
	output logic busy_out
);
	state_t state;
	state_t next_state;
	logic [7:0] src_byte;
	logic step_down;
	logic hold_off;
	logic take_irq;
	logic take_macro;
	logic acceptable;
	logic issue_fire;
	flags_t cmp_flags;
	logic issue_taken;
	logic [7:0] check_diff;

	assign issue_fire = issue_valid_in && issue_ready_out;
	assign issue_ready_out = (state == ST_IDLE);
	// Write port exists only to show it is never used by this block
	assign mem_wr_out = 1'b0;
	assign cmp_flags = sub_flags(mem_data_in, src_byte);

	// Acknowledge gating; hold_off covers one instruction after enable or mask
	assign acceptable = !hold_off && (irq_maskable_in ? irq_accept_enable_flag : 1'b1);
	assign take_irq = irq_req_in && acceptable && (state == ST_IDLE || state == ST_COMPARE);
	assign take_macro = macro_req_in && !hold_off && (state == ST_IDLE || state == ST_COMPARE) && !take_irq;

	// Next state; a compare is checked for suspension only between byte steps
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (take_irq || take_macro) begin
					next_state = ST_IDLE;
				end else if (issue_fire && issue_instr_in.op == OP_BLOCK_COMPARE) begin
					next_state = (count_in == 8'h00) ? ST_IDLE : ST_READ_SRC;
				end else if (issue_fire && issue_instr_in.op == OP_NOP) begin
					next_state = ST_NOP_WAIT;
				end
			end
			ST_READ_SRC: next_state = ST_READ_DST;
			ST_READ_DST: next_state = ST_COMPARE;
			ST_COMPARE: begin
				if (cmp_flags.borrow_out_flag || count_out == 8'h01) begin
					next_state = ST_IDLE;
				end else if (take_irq || take_macro) begin
					next_state = ST_SUSPENDED;
				end else begin
					next_state = ST_READ_SRC;
				end
			end
			ST_NOP_WAIT: next_state = ST_IDLE;
			ST_SUSPENDED: begin
				if (resume_in) begin
					next_state = ST_READ_SRC;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Memory read sequencing: source byte first, then target
	always_comb begin
		mem_rd_out = (state == ST_READ_SRC) || (state == ST_READ_DST);
		mem_addr_out = (state == ST_READ_SRC) ? source_pointer_pair_out : target_pointer_pair_out;
	end

	// Capture the source byte; read data arrives in the following cycle
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			src_byte <= 8'h00;
		end else if (state == ST_READ_DST) begin
			src_byte <= mem_data_in;
		end
	end

	// Pointers and count; held while suspended so the return path can resume
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			source_pointer_pair_out <= PTR_RESET;
			target_pointer_pair_out <= PTR_RESET;
			count_out <= COUNT_RESET;
			step_down <= 1'b0;
		end else if (issue_fire && !take_irq && !take_macro && issue_instr_in.op == OP_BLOCK_COMPARE) begin
			source_pointer_pair_out <= source_pointer_pair_in;
			target_pointer_pair_out <= target_pointer_pair_in;
			count_out <= count_in;
			step_down <= issue_instr_in.step_down;
		end else if (state == ST_COMPARE) begin
			source_pointer_pair_out <= step_down ? source_pointer_pair_out - 16'h0001
				: source_pointer_pair_out + 16'h0001;
			target_pointer_pair_out <= step_down ? target_pointer_pair_out - 16'h0001
				: target_pointer_pair_out + 16'h0001;
			count_out <= count_out - 8'h01;
		end
	end

	// Flags follow each subtraction, so the last one stays after the end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flags_out <= '0;
		end else if (state == ST_COMPARE) begin
			flags_out <= cmp_flags;
		end
	end

	// Protected registers: the complement check guards against stray code
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			standby_control_reg <= STANDBY_RESET;
			watchdog_mode_reg <= WATCHDOG_RESET;
		end else if (issue_fire && !take_irq && !take_macro
			&& issue_instr_in.imm == ~issue_instr_in.imm_inv) begin
			if (issue_instr_in.op == OP_WRITE_STANDBY) begin
				standby_control_reg <= issue_instr_in.imm;
			end
			if (issue_instr_in.op == OP_WRITE_WATCHDOG) begin
				watchdog_mode_reg <= issue_instr_in.imm;
			end
		end
	end

	// Trap pulse on a bad complement
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trap_out <= 1'b0;
		end else begin
			trap_out <= issue_fire && !take_irq && !take_macro
				&& (issue_instr_in.op == OP_WRITE_STANDBY || issue_instr_in.op == OP_WRITE_WATCHDOG)
				&& issue_instr_in.imm != ~issue_instr_in.imm_inv;
		end
	end

	// Bank and register set selection
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bank_select_field <= BANK_RESET;
			register_set_select_flag <= 1'b0;
		end else if (issue_fire && !take_irq && !take_macro) begin
			case (issue_instr_in.op)
				OP_TOGGLE_SET: register_set_select_flag <= !register_set_select_flag;
				OP_CHOOSE_BANK: begin
					bank_select_field <= issue_instr_in.bank;
					register_set_select_flag <= 1'b0;
				end
				OP_CHOOSE_BANK_ALT: begin
					bank_select_field <= issue_instr_in.bank;
					register_set_select_flag <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// Interrupt enable and the one-instruction hold-off window
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_accept_enable_flag <= 1'b0;
			hold_off <= 1'b0;
		end else if (issue_fire && !take_irq && !take_macro) begin
			hold_off <= (issue_instr_in.op == OP_ENABLE_IRQ) || (issue_instr_in.op == OP_MASK_IRQ);
			if (issue_instr_in.op == OP_ENABLE_IRQ) begin
				irq_accept_enable_flag <= 1'b1;
			end
			if (issue_instr_in.op == OP_MASK_IRQ) begin
				irq_accept_enable_flag <= 1'b0;
			end
		end
	end

	// Acknowledge and completion pulses
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_ack_out <= 1'b0;
			macro_ack_out <= 1'b0;
			done_out <= 1'b0;
		end else begin
			irq_ack_out <= take_irq;
			macro_ack_out <= take_macro;
			done_out <= (state != ST_IDLE && state != ST_SUSPENDED && next_state == ST_IDLE)
				|| (issue_fire && !take_irq && !take_macro && next_state == ST_IDLE);
		end
	end

	assign busy_out = (state != ST_IDLE);

	a_nop_two_cycles: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_NOP_WAIT) |=> (state == ST_IDLE) && done_out)
		else $error("nop did not finish in two cycles");
	a_no_mem_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		busy_out |-> !mem_wr_out)
		else $error("memory written during compare");
	a_ei_holdoff: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(issue_fire && issue_instr_in.op == OP_ENABLE_IRQ && !take_irq && !take_macro) |=> !take_irq && !take_macro)
		else $error("acknowledge right after enable");
	a_di_holdoff: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(issue_fire && issue_instr_in.op == OP_MASK_IRQ && !take_irq && !take_macro) |=> !take_irq && !take_macro)
		else $error("acknowledge right after mask");
	a_trap_no_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		trap_out |-> $stable(standby_control_reg) && $stable(watchdog_mode_reg))
		else $error("protected write despite trap");
	a_stop_on_borrow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_COMPARE && cmp_flags.borrow_out_flag) |=> state == ST_IDLE)
		else $error("compare ran past source above target");
	a_suspend_keeps: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_SUSPENDED) |=> $stable(count_out) && $stable(source_pointer_pair_out))
		else $error("operands changed while suspended");
	a_flags_last: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_COMPARE) |=> flags_out == $past(cmp_flags))
		else $error("flags not from last subtraction");
	a_alt_bank: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(issue_fire && !take_irq && !take_macro && issue_instr_in.op == OP_CHOOSE_BANK_ALT)
		|=> register_set_select_flag && bank_select_field == $past(issue_instr_in.bank))
		else $error("alternate bank choice wrong");
	a_ctrl_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state != ST_COMPARE) |=> $stable(flags_out))
		else $error("flags moved outside compare");

	// Helpers for the checks below; the difference is formed apart from the flag function
	assign issue_taken = issue_fire && !take_irq && !take_macro;
	assign check_diff = mem_data_in - src_byte;

	// Flag outcomes from bits of the separate difference and from plain comparisons rather than the borrow chain
	a_sign_bit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_COMPARE) |=> flags_out.sign == $past(check_diff[7]))
		else $error("sign flag differs from result bit 7");
	a_zero_result: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_COMPARE) |=> flags_out.zero == ($past(check_diff) == 8'h00))
		else $error("zero flag differs from result");
	a_aux_borrow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_COMPARE) |=> flags_out.aux_carry_flag == $past(mem_data_in[3:0] < src_byte[3:0]))
		else $error("aux carry differs from low nibble borrow");
	a_overflow_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_COMPARE)
		|=> flags_out.par_ovf == $past((mem_data_in[7] ^ src_byte[7]) & (mem_data_in[7] ^ check_diff[7])))
		else $error("overflow flag differs from signed result");
	a_borrow_out: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_COMPARE) |=> flags_out.borrow_out_flag == $past(mem_data_in < src_byte))
		else $error("borrow flag differs from magnitude compare");

	// Sequencing: last byte, empty count, return from suspension, acknowledge points and nop entry
	a_stop_on_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_COMPARE && count_out == 8'h01) |=> state == ST_IDLE && count_out == 8'h00)
		else $error("compare ran past the last byte");
	a_empty_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(issue_taken && issue_instr_in.op == OP_BLOCK_COMPARE && count_in == 8'h00)
		|=> state == ST_IDLE && done_out)
		else $error("empty compare did not end at once");
	a_resume_path: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_SUSPENDED && resume_in) |=> state == ST_READ_SRC)
		else $error("suspended compare did not continue");
	a_suspend_target: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_SUSPENDED) |=> $stable(target_pointer_pair_out))
		else $error("target pointer changed while suspended");
	a_ack_points: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(irq_ack_out || macro_ack_out) |-> $past(state == ST_IDLE || state == ST_COMPARE))
		else $error("acknowledge outside an instruction boundary");
	a_nop_entry: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(issue_taken && issue_instr_in.op == OP_NOP)
		|=> state == ST_NOP_WAIT && !done_out)
		else $error("nop finished in one cycle");

	// Protected registers move only through their own checked instruction
	a_standby_guard: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(issue_taken && issue_instr_in.op == OP_WRITE_STANDBY) |=> $stable(standby_control_reg))
		else $error("standby register moved without its instruction");
	a_watchdog_guard: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(issue_taken && issue_instr_in.op == OP_WRITE_WATCHDOG) |=> $stable(watchdog_mode_reg))
		else $error("watchdog register moved without its instruction");
	a_standby_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(issue_taken && issue_instr_in.op == OP_WRITE_STANDBY && issue_instr_in.imm == ~issue_instr_in.imm_inv)
		|=> standby_control_reg == $past(issue_instr_in.imm))
		else $error("standby write did not land");
	a_watchdog_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(issue_taken && issue_instr_in.op == OP_WRITE_WATCHDOG && issue_instr_in.imm == ~issue_instr_in.imm_inv)
		|=> watchdog_mode_reg == $past(issue_instr_in.imm))
		else $error("watchdog write did not land");
	a_trap_raised: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(issue_taken && (issue_instr_in.op == OP_WRITE_STANDBY || issue_instr_in.op == OP_WRITE_WATCHDOG)
		&& issue_instr_in.imm != ~issue_instr_in.imm_inv) |=> trap_out)
		else $error("bad complement raised no trap");

	// Selection and interrupt state
	a_toggle_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(issue_taken && issue_instr_in.op == OP_TOGGLE_SET)
		|=> register_set_select_flag != $past(register_set_select_flag))
		else $error("set select flag not inverted");
	a_plain_bank: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(issue_taken && issue_instr_in.op == OP_CHOOSE_BANK)
		|=> !register_set_select_flag && bank_select_field == $past(issue_instr_in.bank))
		else $error("plain bank choice wrong");
	a_irq_enable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(issue_taken && issue_instr_in.op == OP_ENABLE_IRQ) |=> irq_accept_enable_flag)
		else $error("enable did not set the accept flag");
	a_irq_mask: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(issue_taken && issue_instr_in.op == OP_MASK_IRQ) |=> !irq_accept_enable_flag)
		else $error("mask did not clear the accept flag");
	a_mask_blocks: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(irq_req_in && irq_maskable_in && !irq_accept_enable_flag) |=> !irq_ack_out)
		else $error("maskable request answered while masked");

	c_compare_suspend: cover property (@(posedge clk_in) disable iff (!rst_n_in) state == ST_SUSPENDED);
	c_trap: cover property (@(posedge clk_in) disable iff (!rst_n_in) trap_out);
	c_compare_end: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		state == ST_COMPARE ##1 state == ST_IDLE);
	c_macro_ack: cover property (@(posedge clk_in) disable iff (!rst_n_in) macro_ack_out && busy_out);
	c_holdoff_hit: cover property (@(posedge clk_in) disable iff (!rst_n_in) hold_off && irq_req_in && issue_fire);
endmodule : cpu_control_and_block_compare
`default_nettype wire

// [src/cpu_ctrl_pkg.sv]
`default_nettype none
package cpu_ctrl_pkg;
	// Instruction codes presented on the decoder's command port
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_BLOCK_COMPARE = 4'h1,
		OP_WRITE_STANDBY = 4'h2,
		OP_WRITE_WATCHDOG = 4'h3,
		OP_TOGGLE_SET = 4'h4,
		OP_CHOOSE_BANK = 4'h5,
		OP_CHOOSE_BANK_ALT = 4'h6,
		OP_NOP = 4'h7,
		OP_ENABLE_IRQ = 4'h8,
		OP_MASK_IRQ = 4'h9
	} op_code_t;

	// Instruction as issued by the fetch stage
	typedef struct packed {
		op_code_t op;
		logic step_down;
		logic [2:0] bank;
		logic [7:0] imm;
		logic [7:0] imm_inv;
	} instr_t;

	// Arithmetic flags
	typedef struct packed {
		logic sign;
		logic zero;
		logic aux_carry_flag;
		logic par_ovf;
		logic borrow_out_flag;
	} flags_t;

	// Flag word field positions
	localparam int FLAG_SIGN_POS = 4;
	localparam int FLAG_ZERO_POS = 3;
	localparam int FLAG_AUX_POS = 2;
	localparam int FLAG_PV_POS = 1;
	localparam int FLAG_CY_POS = 0;

	// Reset values
	localparam logic [7:0] STANDBY_RESET = 8'h00;
	localparam logic [7:0] WATCHDOG_RESET = 8'h00;
	localparam logic [2:0] BANK_RESET = 3'h0;
	localparam logic [15:0] PTR_RESET = 16'h0000;
	localparam logic [7:0] COUNT_RESET = 8'h00;

	// Timing counts
	localparam int NOP_CYCLES = 2;

	// Control sequencer states, Gray coded from ST_IDLE through ST_COMPARE and back to ST_IDLE; ST_COMPARE to ST_READ_SRC changes two bits
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_READ_SRC = 3'b001,
		ST_READ_DST = 3'b011,
		ST_COMPARE = 3'b010,
		ST_NOP_WAIT = 3'b110,
		ST_SUSPENDED = 3'b111
	} state_t;

	// Eight-bit subtract with all flag outcomes (dst minus src)
	function automatic flags_t sub_flags(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] full;
		logic [4:0] low;
		logic [7:0] seven;
		flags_t f;
		full = {1'b0, a} - {1'b0, b};
		low = {1'b0, a[3:0]} - {1'b0, b[3:0]};
		seven = {1'b0, a[6:0]} - {1'b0, b[6:0]};
		f.sign = full[7];
		f.zero = (full[7:0] == 8'h00);
		f.aux_carry_flag = low[4];
		f.par_ovf = seven[7] ^ full[8];
		f.borrow_out_flag = full[8];
		return f;
	endfunction : sub_flags
endpackage : cpu_ctrl_pkg
`default_nettype wire

// [tb/data_mem_model.sv]
`default_nettype none
module data_mem_model (
	// Clock
	input wire logic clk_in,
	// Memory port
	input wire logic mem_rd_in,
	input wire logic [15:0] mem_addr_in,
	input wire logic mem_wr_in,
	output logic [7:0] mem_data_out,
	output logic wr_seen_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ram [0:255];
	initial begin
		mem_data_out = 8'h00;
		wr_seen_out = 1'b0;
	end
	// Data only in the cycle after a read; inverted otherwise so a late sample shows up
	always @(posedge clk_in) begin
		if (mem_rd_in) begin
			mem_data_out <= ram[mem_addr_in[7:0]];
		end else begin
			mem_data_out <= ~mem_data_out;
		end
		if (mem_wr_in) begin
			wr_seen_out <= 1'b1;
		end
	end
endmodule : data_mem_model
`default_nettype wire

// [tb/test_cpu_control_and_block_compare.sv]
`default_nettype none
module test_cpu_control_and_block_compare
	import cpu_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, rst_n_in, issue_valid_in, irq_req_in, irq_maskable_in, macro_req_in, resume_in;
	logic issue_ready_out, done_out, mem_rd_out, mem_wr_out, irq_ack_out, macro_ack_out, trap_out;
	logic register_set_select_flag, irq_accept_enable_flag, busy_out, wr_seen, trapped;
	logic [15:0] source_pointer_pair_in, target_pointer_pair_in, mem_addr_out;
	logic [15:0] source_pointer_pair_out, target_pointer_pair_out;
	logic [7:0] count_in, mem_data_in, count_out, standby_control_reg, watchdog_mode_reg;
	logic [2:0] bank_select_field;
	instr_t issue_instr_in;
	flags_t flags_out, fl;
	int fails = 0;
	int num_checks = 0;
	int acks = 0;
	int cyc;
	cpu_control_and_block_compare dut (.*);
	data_mem_model mem (.clk_in(clk_in), .mem_rd_in(mem_rd_out), .mem_addr_in(mem_addr_out),
		.mem_wr_in(mem_wr_out), .mem_data_out(mem_data_in), .wr_seen_out(wr_seen));
	// Clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// Acks counted on the far edge so a stray one between checks is not missed
	always @(negedge clk_in) begin
		if ((irq_ack_out | macro_ack_out) === 1'b1) begin
			acks <= acks + 1;
		end
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic finish_test();
		if (fails == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	function automatic instr_t mk(input op_code_t op, input logic dn = 1'b0, input logic [2:0] b = 3'h0,
		input logic [7:0] v = 8'h00, input logic [7:0] nv = 8'h00);
		return {op, dn, b, v, nv};
	endfunction : mk
	// Borrow-style compare outcome, written from first principles
	function automatic flags_t exp_f(input logic [7:0] d, input logic [7:0] s);
		logic [7:0] r;
		r = d - s;
		return {r[7], r == 8'h00, d[3:0] < s[3:0], (d[7] ^ s[7]) & (d[7] ^ r[7]), d < s};
	endfunction : exp_f
	task automatic issue(input instr_t i);
		@(posedge clk_in);
		issue_valid_in <= 1'b1;
		issue_instr_in <= i;
		do @(negedge clk_in); while (issue_ready_out !== 1'b1);
		@(posedge clk_in);
		issue_valid_in <= 1'b0;
	endtask : issue
	task automatic wait_end();
		trapped = 1'b0;
		cyc = 0;
		do begin
			@(negedge clk_in);
			cyc++;
			trapped |= trap_out;
		end while (done_out !== 1'b1 && trap_out !== 1'b1 && cyc < 200);
		@(negedge clk_in);
		trapped |= trap_out;
		chk("done", 16'h0000, 16'(cyc >= 200));
	endtask : wait_end
	task automatic blk(input logic dn, input logic [15:0] s, input logic [15:0] t, input logic [7:0] c,
		input logic ir, input logic mc);
		logic [15:0] es;
		logic [15:0] et;
		logic [7:0] ec;
		flags_t ef;
		es = s;
		et = t;
		ec = c;
		ef = flags_out;
		while (ec != 8'h00) begin
			ef = exp_f(mem.ram[et[7:0]], mem.ram[es[7:0]]);
			es = dn ? es - 16'h0001 : es + 16'h0001;
			et = dn ? et - 16'h0001 : et + 16'h0001;
			ec = ec - 8'h01;
			if (ef.borrow_out_flag) break;
		end
		@(posedge clk_in);
		source_pointer_pair_in <= s;
		target_pointer_pair_in <= t;
		count_in <= c;
		issue(mk(OP_BLOCK_COMPARE, dn));
		if (ir | mc) begin
			repeat (5) @(posedge clk_in);
			irq_req_in <= ir;
			macro_req_in <= mc;
			irq_maskable_in <= 1'b0;
			do @(negedge clk_in); while ((irq_ack_out | macro_ack_out) !== 1'b1);
			@(posedge clk_in);
			irq_req_in <= 1'b0;
			macro_req_in <= 1'b0;
			repeat (8) @(negedge clk_in);
			chk("hold", 16'h0001, 16'(busy_out));
			@(posedge clk_in);
			resume_in <= 1'b1;
			@(posedge clk_in);
			resume_in <= 1'b0;
		end
		wait_end();
		chk("src", es, source_pointer_pair_out);
		chk("dst", et, target_pointer_pair_out);
		chk("cnt", 16'(ec), 16'(count_out));
		chk("flags", 16'(ef), 16'(flags_out));
		chk("wr", 16'h0000, 16'(wr_seen));
	endtask : blk
	task automatic prot(input op_code_t op, input logic [7:0] v, input logic [7:0] nv);
		logic [7:0] old;
		logic ok;
		old = (op == OP_WRITE_STANDBY) ? standby_control_reg : watchdog_mode_reg;
		ok = (nv == ~v);
		issue(mk(op, 1'b0, 3'h0, v, nv));
		wait_end();
		chk("trap", 16'(!ok), 16'(trapped));
		chk("prot", 16'(ok ? v : old), 16'(op == OP_WRITE_STANDBY ? standby_control_reg
			: watchdog_mode_reg));
	endtask : prot
	task automatic banks();
		for (int b = 0; b < 8; b++) begin
			issue(mk(OP_CHOOSE_BANK_ALT, 1'b0, b[2:0]));
			wait_end();
			chk("bank", 16'(b), 16'(bank_select_field));
			chk("set", 16'h0001, 16'(register_set_select_flag));
			issue(mk(OP_CHOOSE_BANK, 1'b0, 3'(7 - b)));
			wait_end();
			chk("bank", 16'(7 - b), 16'(bank_select_field));
			chk("set", 16'h0000, 16'(register_set_select_flag));
			issue(mk(OP_TOGGLE_SET));
			wait_end();
			chk("set", 16'h0001, 16'(register_set_select_flag));
		end
	endtask : banks
	// Step count of a one-cycle op is the yardstick, so the reading of done timing cancels out
	task automatic nop_time();
		int a;
		issue(mk(OP_TOGGLE_SET));
		wait_end();
		a = cyc;
		issue(mk(OP_NOP));
		wait_end();
		chk("nop", 16'(NOP_CYCLES - 1), 16'(cyc - a));
	endtask : nop_time
	task automatic hold(input op_code_t op);
		int n;
		issue(mk(op));
		wait_end();
		chk("ie", 16'(op == OP_ENABLE_IRQ), 16'(irq_accept_enable_flag));
		n = acks;
		@(posedge clk_in);
		irq_req_in <= 1'b1;
		irq_maskable_in <= (op == OP_ENABLE_IRQ);
		issue(mk(OP_NOP));
		wait_end();
		chk("early", 16'(n), 16'(acks));
		while (acks == n) @(posedge clk_in);
		irq_req_in <= 1'b0;
	endtask : hold
	// Main sequence
	initial begin
		static logic [7:0] vals [3] = '{8'h00, 8'hA5, 8'hFF};
		int seen;
		rst_n_in = 1'b0;
		{issue_valid_in, irq_req_in, irq_maskable_in, macro_req_in, resume_in} = 5'h00;
		issue_instr_in = '0;
		source_pointer_pair_in = 16'h0000;
		target_pointer_pair_in = 16'h0000;
		count_in = 8'h00;
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(negedge clk_in);
		chk("rst", 16'h0000, {standby_control_reg, watchdog_mode_reg});
		chk("rst", 16'h0000, 16'({flags_out, bank_select_field, register_set_select_flag, irq_accept_enable_flag}));
		for (int i = 0; i < 256; i++) begin
			mem.ram[i] = {1'b0, i[6:0]};
		end
		mem.ram[8'hD3] = 8'h00;
		mem.ram[8'hE2] = 8'h80;
		blk(1'b0, 16'h0010, 16'h0090, 8'h14, 1'b0, 1'b0);
		blk(1'b0, 16'h0050, 16'h00D0, 8'h08, 1'b0, 1'b0);
		blk(1'b1, 16'h0064, 16'h00E4, 8'h03, 1'b0, 1'b0);
		blk(1'b0, 16'h0010, 16'h0090, 8'h14, 1'b1, 1'b0);
		blk(1'b1, 16'h003F, 16'h00BF, 8'h14, 1'b0, 1'b1);
		blk(1'b0, 16'h0020, 16'h00A0, 8'h00, 1'b0, 1'b0);
		fl = flags_out;
		for (int k = 0; k < 3; k++) begin
			prot(OP_WRITE_WATCHDOG, vals[k], ~vals[k]);
			prot(OP_WRITE_STANDBY, vals[k], ~vals[k]);
		end
		prot(OP_WRITE_STANDBY, 8'h3C, 8'h3C);
		prot(OP_WRITE_WATCHDOG, 8'h12, 8'hEC);
		banks();
		nop_time();
		hold(OP_ENABLE_IRQ);
		hold(OP_MASK_IRQ);
		// Maskable request after the mask must stay unanswered
		@(posedge clk_in);
		seen = acks;
		irq_req_in <= 1'b1;
		irq_maskable_in <= 1'b1;
		repeat (4) @(negedge clk_in);
		chk("masked", 16'(seen), 16'(acks));
		@(posedge clk_in);
		irq_req_in <= 1'b0;
		chk("flags", 16'(fl), 16'(flags_out));
		chk("standby", 16'h00FF, 16'(standby_control_reg));
		finish_test();
	end
	// Whole run is a few hundred cycles; a hang is cut off well beyond that
	initial begin
		#200000;
		fails++;
		finish_test();
	end
endmodule : test_cpu_control_and_block_compare
`default_nettype wire
